// File: dcr_sync.sv
`timescale 1ns/100ps
module dcr_sync (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// raw pins and synchronised levels
	input wire logic [dcr_pkg::SYNC_W-1:0] async_i,
	output logic [dcr_pkg::SYNC_W-1:0] sync_o
);
	import dcr_pkg::*;
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;

	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			always_ff @(posedge CLK_I or posedge RST_I) begin
				if (RST_I) begin
					meta_reg[g] <= SYNC_RST[g];
					sync_reg[g] <= SYNC_RST[g];
				end else begin
					meta_reg[g] <= async_i[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_reg;
endmodule

// File: dcr_counter.sv
// Function
// [R01] The count is four bits made of a divide-by-two stage and a separate divide-by-five stage, with no internal link between them.
// [R02] Each stage steps only on a falling edge of its own clock input, and the two clocks are independent.
// [R03] Outside logic must not use decodes of the count bits as clocks or strobes, since the bits settle one after another.
// [R04] When both clear inputs are high and the preset inputs are not both high, all four count bits are cleared, overriding both clocks.
// [R05] When both preset inputs are high the count is forced to nine: bit 0 high, bits 1 and 2 low, bit 3 high.
// [R06] Preset wins over clear and over both clocks when they act together.
// [R07] For decimal counting, outside wiring routes count bit 0 to the divide-by-five clock and the input pulses to the divide-by-two clock.
// [R08] In that decimal wiring the count runs zero to nine, bit 0 least significant, and returns to zero after nine.
// [R09] For a symmetric divide-by-ten, bit 3 drives the divide-by-two clock and the pulses drive the divide-by-five clock, giving a square wave on bit 0.
// [R10] Unlinked, the first flip-flop is a plain divide-by-two clocked by its own clock and seen on bit 0.
// [R11] The divide-by-five clock drives the upper three bits so that bit 3 makes one cycle per five falling edges.
// [R12] Counting happens only while at least one clear input is low and at least one preset input is low.
// [R13] The divide-by-five stage counts zero to four on bits 1 to 3, bit 1 least significant, and wraps to zero on the fifth edge.
`timescale 1ns/100ps
// package sits here so it is compiled before every user of it in this and later files
package dcr_pkg;
	localparam int CNT_W = 4;
	localparam int HI_W = 3;
	localparam int SYNC_W = 6;
	// positions in the synchronised input vector
	localparam int IN_DIV2 = 0;
	localparam int IN_DIV5 = 1;
	localparam int IN_CLR_A = 2;
	localparam int IN_CLR_B = 3;
	localparam int IN_PRE_A = 4;
	localparam int IN_PRE_B = 5;
	// clock pins idle high, so their synchronisers reset high
	localparam logic [SYNC_W-1:0] SYNC_RST = 6'h03;
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_NINE = 4'h9;
	localparam logic [HI_W-1:0] HI_LAST = 3'h4;
	localparam logic [HI_W-1:0] HI_ZERO = 3'h0;
	localparam logic [HI_W-1:0] HI_STEP = 3'h1;
endpackage

module dcr_counter (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// stage clocks, active on falling edge
	input wire logic DIV2_CLOCK_N_I,
	input wire logic DIV5_CLOCK_N_I,
	// clear and preset-to-nine pairs
	input wire logic CLEAR_IN_A_I,
	input wire logic CLEAR_IN_B_I,
	input wire logic PRESET_NINE_A_I,
	input wire logic PRESET_NINE_B_I,
	// count
	output logic [dcr_pkg::CNT_W-1:0] COUNT_O
);
	import dcr_pkg::*;

	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] lvl;
	logic div2_prev_reg;
	logic div2_prev_next;
	logic div5_prev_reg;
	logic div5_prev_next;
	logic lo_reg;
	logic lo_next;
	logic [HI_W-1:0] hi_reg;
	logic [HI_W-1:0] hi_next;
	logic fall2;
	logic fall5;
	logic clear_act;
	logic preset_act;
	logic idle;

	assign pins = {PRESET_NINE_B_I, PRESET_NINE_A_I, CLEAR_IN_B_I,
		CLEAR_IN_A_I, DIV5_CLOCK_N_I, DIV2_CLOCK_N_I};

	// pins are foreign to CLK_I, every one goes through two flops
	dcr_sync u_sync (
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.async_i(pins),
		.sync_o(lvl)
	);

	// edges come from the second flop only, never the first
	assign fall2 = div2_prev_reg & ~lvl[IN_DIV2]; // R02
	assign fall5 = div5_prev_reg & ~lvl[IN_DIV5]; // R02
	assign clear_act = lvl[IN_CLR_A] & lvl[IN_CLR_B]; // R04
	assign preset_act = lvl[IN_PRE_A] & lvl[IN_PRE_B]; // R05
	assign idle = ~clear_act & ~preset_act; // R12

	always_comb begin
		div2_prev_next = lvl[IN_DIV2];
		div5_prev_next = lvl[IN_DIV5];
		lo_next = lo_reg;
		hi_next = hi_reg;
		if (preset_act) begin
			// preset checked first so it beats clear and clocks
			lo_next = CNT_NINE[0]; // R05 R06
			hi_next = CNT_NINE[CNT_W-1:1]; // R05 R06
		end else if (clear_act) begin
			lo_next = CNT_RST[0]; // R04
			hi_next = CNT_RST[CNT_W-1:1]; // R04
		end else begin
			// stages step apart, no internal carry between them
			if (fall2) begin
				lo_next = ~lo_reg; // R01 R10 R09
			end
			if (fall5) begin
				if (hi_reg >= HI_LAST) begin
					hi_next = HI_ZERO; // R13 R11
				end else begin
					hi_next = hi_reg + HI_STEP; // R13
				end
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div2_prev_reg <= 1'b1;
			div5_prev_reg <= 1'b1;
			lo_reg <= CNT_RST[0];
			hi_reg <= CNT_RST[CNT_W-1:1];
		end else begin
			div2_prev_reg <= div2_prev_next;
			div5_prev_reg <= div5_prev_next;
			lo_reg <= lo_next;
			hi_reg <= hi_next;
		end
	end

	// bit 0 below the five-stage gives 8421 order when wired for decimal
	assign COUNT_O = {hi_reg, lo_reg}; // R08

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	chk_preset_nine: assert property (preset_act |=> COUNT_O == CNT_NINE) // R05
		else $error("preset did not load nine");
	chk_preset_wins: assert property ( // R06
		preset_act && clear_act && fall5
		|=> hi_reg == CNT_NINE[CNT_W-1:1])
		else $error("preset lost to clear or clock");
	chk_clear_zero: assert property ( // R04
		clear_act && !preset_act |=> COUNT_O == CNT_RST)
		else $error("clear did not zero the count");
	chk_div2_toggle: assert property ( // R10
		fall2 && idle |=> lo_reg != $past(lo_reg))
		else $error("bit 0 missed a falling edge");
	chk_div2_hold: assert property ( // R02
		!fall2 && idle |=> $stable(lo_reg))
		else $error("bit 0 moved without its clock");
	chk_div5_hold: assert property ( // R02
		!fall5 && idle |=> $stable(hi_reg))
		else $error("upper stage moved without its clock");
	chk_stage_apart: assert property ( // R01
		fall2 && !fall5 && idle |=> $stable(hi_reg))
		else $error("upper stage moved on lower clock");
	chk_lo_apart: assert property ( // R01
		fall5 && !fall2 && idle |=> $stable(lo_reg))
		else $error("bit 0 moved on upper clock");
	// both clocks may fall in one cycle, neither edge may be lost
	chk_both_step: assert property ( // R02
		fall2 && fall5 && idle
		|=> lo_reg != $past(lo_reg) && hi_reg != $past(hi_reg))
		else $error("a stage missed a shared falling edge");
	chk_div5_step: assert property ( // R13
		fall5 && idle && hi_reg < HI_LAST
		|=> hi_reg == $past(hi_reg) + HI_STEP)
		else $error("upper stage did not step by one");
	chk_div5_wrap: assert property ( // R11
		fall5 && idle && hi_reg == HI_LAST |=> hi_reg == HI_ZERO)
		else $error("upper stage did not wrap after four");
	// same hold kind twice: edges inside it are dropped, not queued
	chk_count_frozen: assert property ( // R12
		!idle ##1 !idle && $stable(preset_act) |=> $stable(COUNT_O))
		else $error("count moved while held");
	chk_hi_range: assert property (hi_reg <= HI_LAST) // R13
		else $error("upper stage left zero to four");

	cov_wrap: cover property (fall5 && idle && hi_reg == HI_LAST);
	cov_preset_over_clear: cover property (preset_act && clear_act);
	cov_bcd_nine: cover property (idle && COUNT_O == CNT_NINE ##1
		fall2 && idle);
	cov_both_fall: cover property (fall2 && fall5 && idle);
	cov_clock_held: cover property (clear_act && !preset_act
		&& (fall2 || fall5));
endmodule

// File: dcr_pulse_src.sv
`timescale 1ns/100ps
module dcr_pulse_src (
	// wiring mode, pulses and fed-back count
	input wire logic [1:0] mode_i,
	input wire logic pa_n_i,
	input wire logic pb_n_i,
	input wire logic [dcr_pkg::CNT_W-1:0] count_i,
	// stage clocks
	output logic div2_n_o,
	output logic div5_n_o
);
	import dcr_pkg::*;
	// single count bits only, a decode of several could glitch as a clock
	assign div2_n_o = (mode_i == 2'h2) ? count_i[3] : pa_n_i;
	assign div5_n_o = (mode_i == 2'h1) ? count_i[0] :
		(mode_i == 2'h2) ? pa_n_i : pb_n_i;
endmodule

// File: decade_ripple_counter_test.sv
`timescale 1ns/100ps
module decade_ripple_counter_test;
	import dcr_pkg::*;
	logic CLK_I = 1'h0;
	logic RST_I, p_n, pb_n, ca, cb, pa, pb, d2_n, d5_n;
	logic [1:0] mode;
	logic [CNT_W-1:0] cnt;
	int num_errors, checked;
	dcr_counter uut (.CLK_I(CLK_I), .RST_I(RST_I), .DIV2_CLOCK_N_I(d2_n),
		.DIV5_CLOCK_N_I(d5_n), .CLEAR_IN_A_I(ca), .CLEAR_IN_B_I(cb),
		.PRESET_NINE_A_I(pa), .PRESET_NINE_B_I(pb), .COUNT_O(cnt));
	dcr_pulse_src src (.mode_i(mode), .pa_n_i(p_n), .pb_n_i(pb_n),
		.count_i(cnt), .div2_n_o(d2_n), .div5_n_o(d5_n));
	initial forever #2.5 CLK_I = ~CLK_I;
	task automatic final_report();
		$display("checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge CLK_I);
		num_errors++;
		final_report();
	end
	task automatic chk(input logic [CNT_W-1:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// low and high levels both long enough for the loop latency
	task automatic pulse();
		{p_n, pb_n} = 2'h0;
		repeat (4) @(negedge CLK_I);
		{p_n, pb_n} = 2'h3;
		repeat (5) @(negedge CLK_I);
	endtask
	// upper stage clock alone, bit 0 must stay put
	task automatic pulse_b();
		pb_n = 1'h0;
		repeat (4) @(negedge CLK_I);
		pb_n = 1'h1;
		repeat (5) @(negedge CLK_I);
	endtask
	// rewiring under clear, so a false edge from the switch is dropped
	task automatic start(input logic [1:0] m);
		{ca, cb} = 2'h3;
		repeat (1) @(negedge CLK_I);
		mode = m;
		repeat (4) @(negedge CLK_I);
		{ca, cb} = 2'h0;
	endtask
	task automatic t_bcd();
		start(2'h1);
		for (int i = 1; i <= 11; i++) begin
			pulse();
			chk(cnt, 4'(i % 10));
		end
		$display("bcd test done");
	endtask
	task automatic t_div10();
		start(2'h2);
		for (int i = 1; i <= 12; i++) begin
			pulse();
			chk(cnt, {3'(i % 5), 1'((i / 5) % 2)});
		end
		$display("div10 test done");
	endtask
	task automatic t_force();
		start(2'h0);
		pa = 1'h1;
		pulse();
		chk(cnt, 4'h3);
		pulse_b();
		chk(cnt, 4'h5);
		{pb, ca, cb} = 3'h7;
		pulse();
		chk(cnt, 4'h9);
		{pa, pb} = 2'h0;
		pulse();
		chk(cnt, 4'h0);
		$display("force test done");
	endtask
	initial begin
		{RST_I, p_n, pb_n, ca, cb, pa, pb} = 7'h70;
		mode = 2'h0;
		repeat (3) @(negedge CLK_I);
		RST_I = 1'h0;
		t_bcd();
		t_div10();
		t_force();
		final_report();
	end
endmodule
